// ### design/divider_pkg.sv
// package for the counter frequency divider: constants, enums and carrier structs
// assumes a single 100 MHz clock domain; no register bus, all settings are plain ports
package divider_pkg;

  localparam int          COUNT_WIDTH     = 32;
  localparam real         CLK_PERIOD_NS   = 10.0;
  localparam logic        GATE_UNGATED    = 1'h0;
  localparam logic        GATE_HIGH       = 1'h1;
  localparam logic        DIR_SRC_SW      = 1'h0;
  localparam logic        DIR_SRC_PIN     = 1'h1;
  localparam logic        DIR_DOWN        = 1'h0;
  localparam logic        DIR_UP          = 1'h1;
  localparam logic [31:0] DIVISOR_RESET   = 32'h0000_0002;
  localparam logic [31:0] COUNT_ONE       = 32'h0000_0001;
  localparam logic [31:0] COUNT_ZERO      = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RUN   = 2'b01
  } run_state_t;

  // software settings that together select the counting behaviour
  typedef struct packed {
    logic        use_internal;   // timebase setting above zero
    logic        gate_mode;
    logic        dir_source;
    logic        dir_sw;
    logic [31:0] divisor;
  } divider_cfg_t;

endpackage

// ### design/edge_sync.sv
// two-stage synchroniser with a registered rising-edge detector
// assumes the input is asynchronous to clk; ce freezes all state
`timescale 1ns/1ps
module edge_sync (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic ce,
  input  wire logic async_in,
  output logic      level,
  output logic      rise
);

  logic meta_q;
  logic meta_d;
  logic level_q;
  logic level_d;
  logic prev_q;
  logic prev_d;

  always_comb begin
    meta_d  = ce ? async_in : meta_q;
    level_d = ce ? meta_q : level_q;
    prev_d  = ce ? level_q : prev_q;
  end

  // only the second stage reads the first
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_q  <= 1'b0;
      level_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      meta_q  <= meta_d;
      level_q <= level_d;
      prev_q  <= prev_d;
    end
  end

  assign level = level_q;
  assign rise  = level_q & ~prev_q;

endmodule

// ### design/counter_frequency_divider.sv
// general-purpose counter used as a frequency divider
// assumes pins are asynchronous to clk and the settings are held stable while running
`timescale 1ns/1ps
// Functional notes
// - output frequency equals selected input clock frequency over the divisor
// - timebase setting zero or less counts external pin rising edges, else internal cycles
// - gate mode 0 ignores the gate and counts once software starts
// - gate mode 1 counts only while gate is high, holds while low
// - direction source 0 uses software bit, 1 uses the direction pin
// - software direction 0 counts down, 1 counts up
// - divisor is the load value, setting input cycles per output period
module counter_frequency_divider #(
  parameter int COUNT_WIDTH = divider_pkg::COUNT_WIDTH
) (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic                     ce,
  input  wire divider_pkg::divider_cfg_t cfg,
  input  wire logic                     start,
  input  wire logic                     stop,
  input  wire logic                     ext_count_clock_pin,
  input  wire logic                     gate_pin,
  input  wire logic                     direction_pin,
  output logic                          divider_output_pin,
  output logic                          running,
  output logic [COUNT_WIDTH-1:0]        count_value
);

  logic                   ext_rise;
  logic                   gate_level;
  logic                   dir_level;
  divider_pkg::run_state_t state_q;
  divider_pkg::run_state_t state_d;
  logic [COUNT_WIDTH-1:0] count_q;
  logic [COUNT_WIDTH-1:0] count_d;
  logic                   out_q;
  logic                   out_d;
  logic                   running_q;
  logic                   running_d;
  logic                   tick;
  logic                   enable;
  logic                   count_up;
  logic [COUNT_WIDTH-1:0] load;

  localparam logic [COUNT_WIDTH-1:0] CNT_ONE  = COUNT_WIDTH'(divider_pkg::COUNT_ONE);
  localparam logic [COUNT_WIDTH-1:0] CNT_ZERO = COUNT_WIDTH'(divider_pkg::COUNT_ZERO);

  edge_sync u_ext_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .ce       (ce),
    .async_in (ext_count_clock_pin),
    .level    (),
    .rise     (ext_rise)
  );

  edge_sync u_gate_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .ce       (ce),
    .async_in (gate_pin),
    .level    (gate_level),
    .rise     ()
  );

  edge_sync u_dir_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .ce       (ce),
    .async_in (direction_pin),
    .level    (dir_level),
    .rise     ()
  );

  // a divisor of zero behaves as one so the output never stalls
  function automatic logic [COUNT_WIDTH-1:0] safe_div(input logic [31:0] d);
    safe_div = (d == divider_pkg::COUNT_ZERO) ? COUNT_WIDTH'(divider_pkg::COUNT_ONE) : COUNT_WIDTH'(d);
  endfunction

  always_comb begin
    load     = safe_div(cfg.divisor);
    tick     = cfg.use_internal ? 1'b1 : ext_rise;
    enable   = (cfg.gate_mode == divider_pkg::GATE_UNGATED) ? 1'b1 : gate_level;
    count_up = (cfg.dir_source == divider_pkg::DIR_SRC_PIN) ? dir_level
             : (cfg.dir_sw == divider_pkg::DIR_UP);
  end

  // up-counting runs 0..divisor-1, down-counting divisor..1; both wrap after divisor ticks
  always_comb begin
    state_d = state_q;
    count_d = count_q;
    out_d   = 1'b0;
    if (ce) begin
      case (state_q)
        divider_pkg::ST_IDLE: begin
          if (start) begin
            state_d = divider_pkg::ST_RUN;
            count_d = count_up ? COUNT_WIDTH'(divider_pkg::COUNT_ZERO) : load;
          end
        end
        divider_pkg::ST_RUN: begin
          if (stop) begin
            state_d = divider_pkg::ST_IDLE;
          end else if (tick && enable) begin
            if (count_up) begin
              if (count_q >= load - COUNT_WIDTH'(divider_pkg::COUNT_ONE)) begin
                count_d = COUNT_WIDTH'(divider_pkg::COUNT_ZERO);
                out_d   = 1'b1;
              end else begin
                count_d = count_q + COUNT_WIDTH'(divider_pkg::COUNT_ONE);
              end
            end else begin
              if (count_q <= COUNT_WIDTH'(divider_pkg::COUNT_ONE)) begin
                count_d = load;
                out_d   = 1'b1;
              end else begin
                count_d = count_q - COUNT_WIDTH'(divider_pkg::COUNT_ONE);
              end
            end
          end
        end
        default: state_d = divider_pkg::ST_IDLE;
      endcase
    end else begin
      out_d = out_q;
    end
    // registered copy so the status output leaves a flop directly
    running_d = (state_d == divider_pkg::ST_RUN);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= divider_pkg::ST_IDLE;
      count_q <= COUNT_WIDTH'(divider_pkg::COUNT_ZERO);
      out_q     <= 1'b0;
      running_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      count_q   <= count_d;
      out_q     <= out_d;
      running_q <= running_d;
    end
  end

  assign divider_output_pin = out_q;
  assign running            = running_q;
  assign count_value        = count_q;

  // pulse lasts one enabled cycle only; a divisor of one on the internal timebase legally pulses every cycle
  AST_PULSE_ONE: assert property (@(posedge clk) disable iff (!reset_n)
    (divider_output_pin && ce && load != CNT_ONE) |=> !divider_output_pin)
    else $error("divider pulse longer than one cycle");

  AST_NO_PULSE_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
    (!running && ce) |=> !divider_output_pin)
    else $error("divider pulse while idle");

  AST_GATE_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    (running && ce && !stop && cfg.gate_mode && !gate_level) |=> $stable(count_value))
    else $error("count moved with gate low");

  AST_EXT_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    (running && ce && !stop && !cfg.use_internal && !ext_rise) |=> $stable(count_value))
    else $error("count moved without external edge");

  AST_INT_ADV: assert property (@(posedge clk) disable iff (!reset_n)
    (running && ce && !stop && cfg.use_internal && !cfg.gate_mode && load > 32'h2)
      |=> !$stable(count_value))
    else $error("ungated internal count stalled");

  AST_DOWN_STEP: assert property (@(posedge clk) disable iff (!reset_n)
    (running && ce && !stop && enable && tick && !cfg.dir_source && !cfg.dir_sw && count_value > 32'h1)
      |=> count_value == $past(count_value) - 32'h1)
    else $error("software down count wrong");

  AST_PIN_DIR: assert property (@(posedge clk) disable iff (!reset_n)
    (running && ce && !stop && enable && tick && cfg.dir_source && dir_level && count_value < load - 32'h1)
      |=> count_value == $past(count_value) + 32'h1)
    else $error("pin direction not followed");

  AST_RELOAD: assert property (@(posedge clk) disable iff (!reset_n)
    (running && ce && !stop && enable && tick && !count_up && count_value <= 32'h1)
      |=> (count_value == load) && divider_output_pin)
    else $error("terminal count did not reload");

  AST_START_DOWN: assert property (@(posedge clk) disable iff (!reset_n)
    (!running && ce && start && !count_up) |=> running && (count_value == load))
    else $error("down count did not load the divisor at start");

  AST_START_UP: assert property (@(posedge clk) disable iff (!reset_n)
    (!running && ce && start && count_up) |=> running && (count_value == CNT_ZERO))
    else $error("up count did not start from zero");

  AST_UP_STEP: assert property (@(posedge clk) disable iff (!reset_n)
    (running && ce && !stop && enable && tick && !cfg.dir_source && cfg.dir_sw && count_value < load - CNT_ONE)
      |=> count_value == $past(count_value) + CNT_ONE)
    else $error("software up count wrong");

  AST_UP_WRAP: assert property (@(posedge clk) disable iff (!reset_n)
    (running && ce && !stop && enable && tick && count_up && count_value >= load - CNT_ONE)
      |=> (count_value == CNT_ZERO) && divider_output_pin)
    else $error("up count did not wrap with a pulse");

  AST_PIN_DOWN: assert property (@(posedge clk) disable iff (!reset_n)
    (running && ce && !stop && enable && tick && cfg.dir_source && !dir_level && count_value > CNT_ONE)
      |=> count_value == $past(count_value) - CNT_ONE)
    else $error("pin down direction not followed");

  AST_GATED_ADV: assert property (@(posedge clk) disable iff (!reset_n)
    (running && ce && !stop && cfg.use_internal && cfg.gate_mode && gate_level && load != CNT_ONE)
      |=> !$stable(count_value))
    else $error("gated count stalled with gate high");

  AST_EXT_ADV: assert property (@(posedge clk) disable iff (!reset_n)
    (running && ce && !stop && !cfg.use_internal && ext_rise && enable && load != CNT_ONE)
      |=> !$stable(count_value))
    else $error("external edge not counted");

  AST_STOP_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
    (running && ce && stop) |=> !running && !divider_output_pin)
    else $error("stop did not return to idle");

  // a low enable must freeze everything, including a pulse in flight
  AST_CE_FREEZE: assert property (@(posedge clk) disable iff (!reset_n)
    (!ce) |=> $stable(count_value) && $stable(divider_output_pin) && $stable(running))
    else $error("state moved with clock enable low");

  COV_PULSE: cover property (@(posedge clk) divider_output_pin);
  COV_GATED: cover property (@(posedge clk) running && cfg.gate_mode && !gate_level);
  COV_UP_WRAP: cover property (@(posedge clk) running && count_up && divider_output_pin);
  COV_EXT_PULSE: cover property (@(posedge clk) running && !cfg.use_internal && divider_output_pin);
  COV_FROZEN: cover property (@(posedge clk) running && !ce);

endmodule

// ### test/signal_source.sv
// partner model: external count clock, gate and direction sources
// assumes the bench sets the half period in clk cycles; the clock stands low when disabled
`timescale 1ns/1ps
module signal_source (
  input  wire logic       clk,
  input  wire logic       en,
  input  wire logic [7:0] half,
  input  wire logic       gate_set,
  input  wire logic       dir_set,
  output logic            ext_clk,
  output logic            gate,
  output logic            dir
);
  logic [7:0] cnt;
  // a divided clock stays free of the bench's own drive timing
  always_ff @(posedge clk) begin
    if (!en) begin
      cnt     <= 8'h00;
      ext_clk <= 1'h0;
    end else if (cnt == half - 8'h01) begin
      cnt     <= 8'h00;
      ext_clk <= ~ext_clk;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
  assign gate = gate_set;
  assign dir  = dir_set;
endmodule

// ### test/tb_counter_frequency_divider.sv
// testbench for the counter frequency divider
// assumes the partner model drives the pins; settings held stable while running
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_counter_frequency_divider;
  logic clk, reset_n, ce, start, stop, en, gate_set, dir_set, ext_clk, gate, dir, out, running;
  logic [7:0]  half;
  logic [31:0] count;
  divider_pkg::divider_cfg_t cfg;
  int n_errors, checks_done;
  signal_source i_src (.clk(clk), .en(en), .half(half), .gate_set(gate_set), .dir_set(dir_set),
                       .ext_clk(ext_clk), .gate(gate), .dir(dir));
  counter_frequency_divider i_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .cfg(cfg), .start(start),
    .stop(stop), .ext_count_clock_pin(ext_clk), .gate_pin(gate), .direction_pin(dir),
    .divider_output_pin(out), .running(running), .count_value(count));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // configure, issue a one-cycle start and return with the loaded start count visible
  task automatic go(logic ui, logic gm, logic ds, logic dw, logic [31:0] dv);
    cfg = '{use_internal: ui, gate_mode: gm, dir_source: ds, dir_sw: dw, divisor: dv};
    start = 1'h1;
    tick();
    start = 1'h0;
    `CHK(running, 1'h1)
  endtask
  task automatic halt();
    stop = 1'h1;
    tick();
    stop = 1'h0;
    tick();
    `CHK(running, 1'h0)
  endtask
  // cycles between two successive output pulses; a missing pulse ends the run
  task automatic period(output int p);
    bit seen;
    seen = 0;
    p = 0;
    for (int i = 0; i < 3000; i++) begin
      tick();
      if (seen) p++;
      if (out === 1'h1) begin
        if (seen) return;
        seen = 1;
      end
    end
    n_errors++;
    wrap_up();
  endtask
  task automatic t_down_internal();
    int p;
    go(1'h1, divider_pkg::GATE_UNGATED, divider_pkg::DIR_SRC_SW, divider_pkg::DIR_DOWN, 32'h0000_0003);
    `CHK(count, 32'h0000_0003)
    tick();
    `CHK(count, 32'h0000_0002)
    tick();
    tick();
    `CHK(out, 1'h1)
    `CHK(count, 32'h0000_0003)
    tick();
    `CHK(out, 1'h0)
    period(p);
    `CHK(p, 3)
    halt();
    $display("test down_internal done");
  endtask
  task automatic t_up_ungated();
    int p;
    gate_set = 1'h0;
    go(1'h1, divider_pkg::GATE_UNGATED, divider_pkg::DIR_SRC_SW, divider_pkg::DIR_UP, 32'h0000_0004);
    `CHK(count, 32'h0000_0000)
    tick();
    `CHK(count, 32'h0000_0001)
    period(p);
    `CHK(p, 4)
    halt();
    $display("test up_ungated done");
  endtask
  task automatic t_gated();
    int p;
    logic [31:0] c;
    gate_set = 1'h0;
    go(1'h1, divider_pkg::GATE_HIGH, divider_pkg::DIR_SRC_SW, divider_pkg::DIR_DOWN, 32'h0000_0005);
    repeat (8) tick();
    `CHK(count, 32'h0000_0005)
    `CHK(out, 1'h0)
    gate_set = 1'h1;
    period(p);
    `CHK(p, 5)
    gate_set = 1'h0;
    repeat (4) tick();
    c = count;
    repeat (5) tick();
    `CHK(count, c)
    `CHK(out, 1'h0)
    halt();
    $display("test gated done");
  endtask
  task automatic t_dir_pin();
    dir_set = 1'h1;
    // the pin passes two synchroniser stages before the start edge may see it
    repeat (3) tick();
    go(1'h1, divider_pkg::GATE_UNGATED, divider_pkg::DIR_SRC_PIN, divider_pkg::DIR_DOWN, 32'h0000_0009);
    `CHK(count, 32'h0000_0000)
    tick();
    `CHK(count, 32'h0000_0001)
    halt();
    dir_set = 1'h0;
    repeat (4) tick();
    go(1'h1, divider_pkg::GATE_UNGATED, divider_pkg::DIR_SRC_PIN, divider_pkg::DIR_UP, 32'h0000_0009);
    `CHK(count, 32'h0000_0009)
    halt();
    $display("test dir_pin done");
  endtask
  task automatic t_ce_hold();
    go(1'h1, divider_pkg::GATE_UNGATED, divider_pkg::DIR_SRC_SW, divider_pkg::DIR_DOWN, 32'h0000_0005);
    ce = 1'h0;
    repeat (4) tick();
    `CHK(count, 32'h0000_0005)
    `CHK(running, 1'h1)
    ce = 1'h1;
    tick();
    `CHK(count, 32'h0000_0004)
    halt();
    $display("test ce_hold done");
  endtask
  task automatic t_external();
    int p;
    en = 1'h1;
    go(1'h0, divider_pkg::GATE_UNGATED, divider_pkg::DIR_SRC_SW, divider_pkg::DIR_DOWN, 32'h0000_0003);
    period(p);
    `CHK(p, 18)
    halt();
    en = 1'h0;
    $display("test external done");
  endtask
  initial begin
    {reset_n, start, stop, en, gate_set, dir_set} = 6'h00;
    ce = 1'h1;
    half = 8'h03;
    cfg = '{use_internal: 1'h1, gate_mode: 1'h0, dir_source: 1'h0, dir_sw: 1'h0, divisor: 32'h2};
    n_errors = 0;
    checks_done = 0;
    repeat (5) tick();
    reset_n = 1'h1;
    repeat (4) tick();
    t_down_internal();
    t_up_ungated();
    t_gated();
    t_dir_pin();
    t_ce_hold();
    t_external();
    wrap_up();
  end
endmodule
